// >>> hw/pmrs_pkg.sv
/*
 * constants for the power-mode and reset sequencer: register offsets,
 * field positions, reset values and timing counts.
 * assumes a 125 MHz system clock and a 32-bit apb register bus.
 */
package pmrs_pkg;
	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] POWER_CONTROL_OFS = 8'h00; // idle/power-down control
	localparam logic [7:0] POWER_MODE_OFS    = 8'h04; // rc wake select
	localparam logic [7:0] WAKE_ENABLE_OFS   = 8'h08; // interrupt enables
	localparam logic [7:0] WATCHDOG_OFS      = 8'h0C; // watchdog control/flag
	localparam logic [7:0] STATUS_OFS        = 8'h10; // state and cause flags

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int IDLE_BIT       = 0; // power_control_reg.0
	localparam int PDOWN_BIT      = 1; // power_control_reg.1
	localparam int SKIP_ISR_BIT   = 4; // idle_wake_skip_isr
	localparam int RC_SEL_BIT     = 5; // rc_wake_select in power_mode_reg
	localparam int GIE_BIT        = 7; // global_interrupt_enable
	localparam int WD_RST_EN_BIT  = 0; // watchdog reset enable
	localparam int WD_INT_EN_BIT  = 1; // watchdog interrupt enable
	localparam int WD_RESTART_BIT = 2; // write 1: restart watchdog
	localparam int WD_FLAG_BIT    = 3; // watchdog_timeout_flag
	localparam int POR_FLAG_BIT   = 8; // status: power-on cause
	localparam int WDR_FLAG_BIT   = 9; // status: watchdog cause

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] POWER_CONTROL_RST = 8'h00;
	localparam logic [7:0] POWER_MODE_RST    = 8'h00;
	localparam logic [7:0] WAKE_ENABLE_RST   = 8'h00;
	localparam logic [3:0] WATCHDOG_RST      = 4'h0;
	localparam logic [7:0] PORT_RST          = 8'hFF;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PER_MC      = 4;     // clocks per machine cycle
	localparam int WARMUP_CLOCKS   = 65536; // oscillator warm-up
	localparam int WD_GRACE_CLOCKS = 512;   // time-out to reset
	localparam int EXT_HOLD_MC     = 2;     // least reset pin hold
	localparam int RST_TAIL_MC     = 2;     // reset held after release
	localparam int RST_TAIL_CLOCKS = RST_TAIL_MC * CLK_PER_MC;

	// sequencer states, one-hot
	typedef enum logic [4:0] {
		PMRS_RUN    = 5'b00001,
		PMRS_IDLE   = 5'b00010,
		PMRS_PDOWN  = 5'b00100,
		PMRS_WARMUP = 5'b01000,
		PMRS_RESET  = 5'b10000
	} pmrs_state_e;
endpackage

// >>> hw/pmrs_top.sv
/*
 * power-mode and reset sequencer of the microcontroller: idle and
 * power-down entry and exit, clock gating, port hold, warm-up, and
 * external/watchdog/power-on reset sequencing, with an apb register file.
 * assumes all inputs synchronous to clk; the cpu core obeys cpu_clk_en,
 * reset_out and wake_service; the watchdog interval counter is outside.
 */
`timescale 1ns/10ps
module pmrs_top (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// external pins and events
	input  wire logic        reset_pin,
	input  wire logic [3:0]  ext_int,
	input  wire logic        ring_detect,
	input  wire logic        por_event,
	input  wire logic        wd_timeout,
	input  wire logic        periph_int,
	// port values
	input  wire logic [7:0]  port_reg,
	output logic      [7:0]  port_out,
	// core control
	output logic             cpu_clk_en,
	output logic             periph_clk_en,
	output logic             osc_en,
	output logic             rc_osc_sel,
	output logic             reset_out,
	output logic             wake_service,
	output logic             pc_zero
);
	// ------------------------------------------------------------
	// state and registers
	// ------------------------------------------------------------
	pmrs_pkg::pmrs_state_e state;          // sequencer state
	pmrs_pkg::pmrs_state_e next_state;     // next state
	logic [7:0]  power_control_reg;        // idle, pdown, skip bits
	logic [7:0]  power_mode_reg;           // rc select
	logic [7:0]  wake_enable;              // int enables + gie
	logic [3:0]  wd_ctrl;                  // watchdog control and flag
	logic        por_flag;                 // power-on cause
	logic        wdr_flag;                 // watchdog cause
	logic [16:0] warm_cnt;                 // warm-up counter
	logic [9:0]  wd_cnt;                   // grace counter
	logic [3:0]  tail_cnt;                 // reset tail counter
	logic [1:0]  mc_phase;                 // machine-cycle phase
	logic [1:0]  pin_hist;                 // pin samples at c4
	logic        warm_is_reset;            // warm-up ends in reset
	logic        wd_reset_req;             // watchdog reset due

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	// true when an apb write to the given offset completes
	function automatic logic wr_hit(input logic [7:0] ofs);
		wr_hit = psel && penable && pwrite && (paddr == ofs);
	endfunction

	logic apb_access;                       // access phase
	logic ctrl_wr;                          // power_control_reg write
	logic int_wake;                         // enabled interrupt present
	logic pd_wake;                          // enabled external/ring
	logic pin_valid;                        // reset pin seen two c4s
	logic c4;                               // machine-cycle state c4

	assign apb_access = psel && penable;
	assign ctrl_wr    = wr_hit(pmrs_pkg::POWER_CONTROL_OFS);
	assign c4         = (mc_phase == 2'h3);
	assign pin_valid  = pin_hist[0] && pin_hist[1];
	// enables 0..3 external pins, 4 ring, 5 other peripheral; watchdog enable is wd_ctrl bit 1
	assign int_wake   = wake_enable[pmrs_pkg::GIE_BIT]
		&& ((|(ext_int & wake_enable[3:0])) || (ring_detect && wake_enable[4])
		|| (periph_int && wake_enable[5])
		|| (wd_ctrl[pmrs_pkg::WD_FLAG_BIT] && wd_ctrl[pmrs_pkg::WD_INT_EN_BIT]));
	// only pins and ring can wake from power-down: watchdog is stopped
	assign pd_wake    = wake_enable[pmrs_pkg::GIE_BIT]
		&& ((|(ext_int & wake_enable[3:0])) || (ring_detect && wake_enable[4]));

	// ------------------------------------------------------------
	// machine-cycle phase and reset pin sampling
	// ------------------------------------------------------------
	// phase counter runs on every clock; in power-down it stands
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mc_phase <= 2'h0;
		end else if (state != pmrs_pkg::PMRS_PDOWN) begin
			mc_phase <= mc_phase + 2'h1;
		end
	end

	// pin sampled once per machine cycle at c4; two samples are needed
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_hist <= 2'h0;
		end else if (state == pmrs_pkg::PMRS_PDOWN) begin
			pin_hist <= 2'h0;                // clock stopped, no sampling
		end else if (c4) begin
			pin_hist <= {pin_hist[0], reset_pin};
		end
	end

	// ------------------------------------------------------------
	// watchdog grace counter
	// ------------------------------------------------------------
	// counts 512 clocks from the flag; restart or clearing cancels it
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wd_cnt       <= 10'h000;
			wd_reset_req <= 1'b0;
		end else if (state == pmrs_pkg::PMRS_RESET || state == pmrs_pkg::PMRS_PDOWN
			|| !wd_ctrl[pmrs_pkg::WD_FLAG_BIT] || !wd_ctrl[pmrs_pkg::WD_RST_EN_BIT]) begin
			wd_cnt       <= 10'h000;
			wd_reset_req <= 1'b0;
		end else begin
			if (wd_cnt == 10'(pmrs_pkg::WD_GRACE_CLOCKS - 1)) begin
				wd_reset_req <= 1'b1;
			end else begin
				wd_cnt <= wd_cnt + 10'h001;
			end
		end
	end

	// ------------------------------------------------------------
	// state machine
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			pmrs_pkg::PMRS_RUN: begin
				if (pin_valid || wd_reset_req) begin
					next_state = pmrs_pkg::PMRS_RESET;
				end else if (ctrl_wr && pwdata[pmrs_pkg::PDOWN_BIT]) begin
					next_state = pmrs_pkg::PMRS_PDOWN;
				end else if (ctrl_wr && pwdata[pmrs_pkg::IDLE_BIT]) begin
					next_state = pmrs_pkg::PMRS_IDLE;
				end
			end
			pmrs_pkg::PMRS_IDLE: begin
				if (pin_valid || wd_reset_req) begin
					next_state = pmrs_pkg::PMRS_RESET;
				end else if (int_wake) begin
					next_state = pmrs_pkg::PMRS_RUN;
				end
			end
			pmrs_pkg::PMRS_PDOWN: begin
				// reset pin is seen asynchronously to restart the oscillator
				if (reset_pin || pd_wake) begin
					next_state = pmrs_pkg::PMRS_WARMUP;
				end
			end
			pmrs_pkg::PMRS_WARMUP: begin
				if (warm_cnt == 17'(pmrs_pkg::WARMUP_CLOCKS - 1)) begin
					next_state = warm_is_reset ? pmrs_pkg::PMRS_RESET : pmrs_pkg::PMRS_RUN;
				end
			end
			pmrs_pkg::PMRS_RESET: begin
				// counted from the pin's release, so the tail never falls short of two machine cycles
				if (!reset_pin && tail_cnt == 4'(pmrs_pkg::RST_TAIL_CLOCKS - 1)) begin
					next_state = pmrs_pkg::PMRS_RUN;
				end
			end
			default: begin
				next_state = pmrs_pkg::PMRS_RESET;
			end
		endcase
		// power-on/fail overrides every state; outputs follow in the same edge
		if (por_event) begin
			next_state = pmrs_pkg::PMRS_RESET;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= pmrs_pkg::PMRS_RESET;
		end else if (por_event) begin
			state <= pmrs_pkg::PMRS_RESET;
		end else begin
			state <= next_state;
		end
	end

	// warm-up counter and its outcome
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			warm_cnt      <= 17'h00000;
			warm_is_reset <= 1'b0;
		end else if (state == pmrs_pkg::PMRS_PDOWN) begin
			warm_cnt      <= 17'h00000;
			warm_is_reset <= reset_pin;
		end else if (state == pmrs_pkg::PMRS_WARMUP) begin
			warm_cnt <= warm_cnt + 17'h00001;
		end
	end

	// reset tail: restarts while the pin stays asserted
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tail_cnt <= 4'h0;
		end else if (state != pmrs_pkg::PMRS_RESET || reset_pin) begin
			tail_cnt <= 4'h0;
		end else if (tail_cnt != 4'(pmrs_pkg::RST_TAIL_CLOCKS - 1)) begin
			tail_cnt <= tail_cnt + 4'h1;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// power control: set by software, idle bit cleared by idle wake, pdown bit by warm-up exit to run
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			power_control_reg <= pmrs_pkg::POWER_CONTROL_RST;
		end else if (state == pmrs_pkg::PMRS_RESET) begin
			power_control_reg <= pmrs_pkg::POWER_CONTROL_RST;
		end else if (ctrl_wr) begin
			power_control_reg <= pwdata[7:0];
		end else if (state == pmrs_pkg::PMRS_IDLE && next_state == pmrs_pkg::PMRS_RUN) begin
			power_control_reg[pmrs_pkg::IDLE_BIT] <= 1'b0;
		end else if (state == pmrs_pkg::PMRS_WARMUP && next_state == pmrs_pkg::PMRS_RUN) begin
			power_control_reg[pmrs_pkg::PDOWN_BIT] <= 1'b0;
		end
	end

	// mode and enable registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			power_mode_reg <= pmrs_pkg::POWER_MODE_RST;
			wake_enable    <= pmrs_pkg::WAKE_ENABLE_RST;
		end else if (state == pmrs_pkg::PMRS_RESET) begin
			power_mode_reg <= pmrs_pkg::POWER_MODE_RST;
			wake_enable    <= pmrs_pkg::WAKE_ENABLE_RST;
		end else begin
			if (wr_hit(pmrs_pkg::POWER_MODE_OFS)) begin
				power_mode_reg <= pwdata[7:0];
			end
			if (wr_hit(pmrs_pkg::WAKE_ENABLE_OFS)) begin
				wake_enable <= pwdata[7:0];
			end
		end
	end

	// watchdog control; flag set wins over a software clear
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wd_ctrl <= pmrs_pkg::WATCHDOG_RST;
		end else if (state == pmrs_pkg::PMRS_RESET) begin
			wd_ctrl <= pmrs_pkg::WATCHDOG_RST;
		end else begin
			if (wr_hit(pmrs_pkg::WATCHDOG_OFS)) begin
				wd_ctrl[1:0] <= pwdata[1:0];
				wd_ctrl[pmrs_pkg::WD_FLAG_BIT] <= pwdata[pmrs_pkg::WD_FLAG_BIT]
					&& !pwdata[pmrs_pkg::WD_RESTART_BIT];
			end
			if (wd_timeout && state != pmrs_pkg::PMRS_PDOWN) begin
				wd_ctrl[pmrs_pkg::WD_FLAG_BIT] <= 1'b1;
			end
		end
	end

	// cause flags: only power-on and watchdog are recorded
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			por_flag <= 1'b1;
			wdr_flag <= 1'b0;
		end else if (por_event) begin
			por_flag <= 1'b1;
			wdr_flag <= 1'b0;
		end else if (state != pmrs_pkg::PMRS_RESET && wd_reset_req) begin
			wdr_flag <= 1'b1;
		end else if (state != pmrs_pkg::PMRS_RESET && pin_valid) begin
			por_flag <= 1'b0;
			wdr_flag <= 1'b0;
		end else if (wr_hit(pmrs_pkg::STATUS_OFS)) begin
			por_flag <= por_flag && !pwdata[pmrs_pkg::POR_FLAG_BIT];
			wdr_flag <= wdr_flag && !pwdata[pmrs_pkg::WDR_FLAG_BIT];
		end
	end

	// ------------------------------------------------------------
	// apb read and answer
	// ------------------------------------------------------------
	// zero-wait slave; unmapped reads give zero and slverr
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
			if (psel && !penable) begin
				if (paddr == pmrs_pkg::POWER_CONTROL_OFS) begin
					prdata <= {24'h000000, power_control_reg};
				end else if (paddr == pmrs_pkg::POWER_MODE_OFS) begin
					prdata <= {24'h000000, power_mode_reg};
				end else if (paddr == pmrs_pkg::WAKE_ENABLE_OFS) begin
					prdata <= {24'h000000, wake_enable};
				end else if (paddr == pmrs_pkg::WATCHDOG_OFS) begin
					prdata <= {28'h0000000, wd_ctrl};
				end else if (paddr == pmrs_pkg::STATUS_OFS) begin
					prdata <= {22'h000000, wdr_flag, por_flag, 3'h0, state};
				end else begin
					pslverr <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cpu_clk_en    <= 1'b0;
			periph_clk_en <= 1'b0;
			osc_en        <= 1'b1;
			reset_out     <= 1'b1;
			pc_zero       <= 1'b1;
			rc_osc_sel    <= 1'b0;
		end else begin
			cpu_clk_en    <= (next_state == pmrs_pkg::PMRS_RUN);
			periph_clk_en <= (next_state == pmrs_pkg::PMRS_RUN)
				|| (next_state == pmrs_pkg::PMRS_IDLE);
			osc_en        <= (next_state != pmrs_pkg::PMRS_PDOWN);
			reset_out     <= (next_state == pmrs_pkg::PMRS_RESET);
			pc_zero       <= (next_state == pmrs_pkg::PMRS_RESET);
			rc_osc_sel    <= (next_state == pmrs_pkg::PMRS_WARMUP)
				&& power_mode_reg[pmrs_pkg::RC_SEL_BIT];
		end
	end

	// wake service request: one-cycle pulse when the core must vector
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wake_service <= 1'b0;
		end else begin
			wake_service <= ((state == pmrs_pkg::PMRS_IDLE) && (next_state == pmrs_pkg::PMRS_RUN)
				&& !power_control_reg[pmrs_pkg::SKIP_ISR_BIT])
				|| ((state == pmrs_pkg::PMRS_WARMUP) && (next_state == pmrs_pkg::PMRS_RUN));
		end
	end

	// port drive: frozen on idle entry, port register in power-down
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			port_out <= pmrs_pkg::PORT_RST;
		end else if (state == pmrs_pkg::PMRS_IDLE) begin
			port_out <= port_out;
		end else begin
			port_out <= port_reg;
		end
	end
endmodule // pmrs_top

// >>> tb/pmrs_monitor.sv
/*
 * checker for the power-mode and reset sequencer, bound to pmrs_top.
 * assumes one clock domain (clk) with nrst as asynchronous reset.
 */
`timescale 1ns/10ps
module pmrs_monitor (
	// clock and reset
	input wire logic       clk,
	input wire logic       nrst,
	// apb handshake
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	// pins and ports
	input wire logic       reset_pin,
	input wire logic [7:0] port_reg,
	input wire logic [7:0] port_out,
	// core control
	input wire logic       cpu_clk_en,
	input wire logic       periph_clk_en,
	input wire logic       osc_en,
	input wire logic       rc_osc_sel,
	input wire logic       reset_out,
	input wire logic       wake_service,
	input wire logic       pc_zero
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic idle; // core stopped, peripherals still clocked
	assign idle = periph_clk_en && !cpu_clk_en;
	// pin rises while awake, then stays high long enough for two samples
	sequence s_pin_held;
		$rose(reset_pin) && periph_clk_en ##1 reset_pin[*8];
	endsequence

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	chk_cpu_gated: assert property (cpu_clk_en |-> periph_clk_en && osc_en)
		else $error("cpu clock runs while peripherals or oscillator are off");
	chk_idle_ports: assert property (idle && $past(idle) && $past(idle, 2) |-> $stable(port_out))
		else $error("port moved while idle");
	chk_pdown_clocks: assert property (!osc_en |-> !cpu_clk_en && !periph_clk_en && !rc_osc_sel)
		else $error("a clock runs in power-down");
	chk_pdown_ports: assert property (!osc_en && !$past(osc_en) |-> port_out == $past(port_reg))
		else $error("power-down port not driven from port register");
	chk_pc_restart: assert property (pc_zero == reset_out)
		else $error("restart at zero not tied to reset");
	chk_wake_pulse: assert property (wake_service |-> cpu_clk_en ##1 !wake_service)
		else $error("service pulse malformed");
	chk_apb_answer: assert property (psel && !penable |=> pready)
		else $error("apb answer missing");
	chk_ext_detect: assert property (s_pin_held |-> ##[0:4] reset_out)
		else $error("held reset pin not detected");
	chk_reset_tail: assert property ($fell(reset_out) |->
		!$past(reset_pin) && !$past(reset_pin, 6) && !$past(reset_pin, 8))
		else $error("reset ended too soon after pin release");
	chk_rc_warm: assert property (rc_osc_sel |-> osc_en && !cpu_clk_en)
		else $error("rc oscillator selected outside warm-up");
endmodule // pmrs_monitor

bind pmrs_top pmrs_monitor i_pmrs_monitor (.clk, .nrst, .psel, .penable, .pready, .reset_pin, .port_reg,
	.port_out, .cpu_clk_en, .periph_clk_en, .osc_en, .rc_osc_sel, .reset_out, .wake_service, .pc_zero);

// >>> tb/pmrs_reset_source.sv
/*
 * model of the external reset source that drives the reset pin.
 * assumes a one-cycle request from the bench, synchronous to clk.
 */
`timescale 1ns/10ps
module pmrs_reset_source #(
	parameter int HOLD = 12 // clocks the pin stays high
) (
	// clock
	input wire logic clk,
	// request from the bench
	input wire logic req,
	// reset pin
	output logic     reset_pin
);
	int cnt = 0; // clocks of hold left
	// a shorter pulse could fall between two samples and be missed
	always @(posedge clk) begin
		if (req) begin
			cnt <= HOLD;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
	end
	assign reset_pin = (cnt != 0);
endmodule // pmrs_reset_source

// >>> tb/test_pmrs_top.sv
/*
 * self-checking bench for pmrs_top: register table, idle, resets,
 * watchdog and power-down wake with warm-up.
 * assumes the monitor is bound and the reset source model is compiled.
 */
`timescale 1ns/10ps
module test_pmrs_top;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic        clk, nrst, psel, penable, pwrite, ring_detect, por_event, wd_timeout, periph_int, rst_req, er;
	logic        pready, pslverr, reset_pin, cpu_clk_en, periph_clk_en, osc_en, rc_osc_sel, reset_out;
	logic        wake_service, pc_zero;
	logic [7:0]  paddr, port_reg, port_out;
	logic [3:0]  ext_int;
	logic [31:0] pwdata, prdata, rd;
	int          n_mismatch = 0, cmp_count = 0, n, i;
	// one register access: write flag, offset, data, read mask, expected, error
	typedef struct {logic wr; logic [7:0] a; logic [31:0] d, m, x; logic e;} pmrs_row_s;
	pmrs_row_s rows [11] = '{
		'{1'b0, 8'h00, 32'h0, 32'hFF, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'hFF, 32'h0, 1'b0},
		'{1'b0, 8'h08, 32'h0, 32'hFF, 32'h0, 1'b0}, '{1'b0, 8'h0C, 32'h0, 32'hF, 32'h0, 1'b0},
		'{1'b0, 8'h10, 32'h0, 32'h1F, 32'h1, 1'b0}, '{1'b1, 8'h10, 32'h300, 32'h0, 32'h0, 1'b0},
		'{1'b0, 8'h10, 32'h0, 32'h300, 32'h0, 1'b0}, '{1'b1, 8'h04, 32'h20, 32'h0, 32'h0, 1'b0},
		'{1'b0, 8'h04, 32'h0, 32'hFF, 32'h20, 1'b0}, '{1'b1, 8'h14, 32'h55, 32'h0, 32'h0, 1'b1},
		'{1'b0, 8'h14, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b1}};

	pmrs_top i_pmrs_top (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.reset_pin, .ext_int, .ring_detect, .por_event, .wd_timeout, .periph_int, .port_reg, .port_out,
		.cpu_clk_en, .periph_clk_en, .osc_en, .rc_osc_sel, .reset_out, .wake_service, .pc_zero);
	pmrs_reset_source i_pmrs_reset_source (.clk, .req(rst_req), .reset_pin);

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// count n must lie in a window
	task automatic rng(input int lo, input int hi);
		chk(32'(n >= lo && n <= hi), 32'h1);
	endtask
	// apb transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 16; k++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (k == 16) n_mismatch++;
		if (k == 16) give_verdict();
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	// wait until a watched output takes value v; n counts the edges
	task automatic wfor(input int s, input logic v, input int lim);
		logic [3:0] pv;
		for (n = 0; n < lim; n++) begin
			@(posedge clk);
			pv = {wake_service, rc_osc_sel, cpu_clk_en, reset_out};
			if (pv[s] === v) return;
		end
		n_mismatch++;
		give_verdict();
	endtask
	task automatic pulse_wd();
		wd_timeout <= 1'b1;
		@(posedge clk);
		wd_timeout <= 1'b0;
	endtask

	// ------------------------------------------------------------
	// clock and main sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		{nrst, psel, penable, pwrite, ring_detect, por_event, wd_timeout, periph_int, rst_req} = 9'h0;
		{paddr, pwdata, ext_int, port_reg} = {8'h0, 32'h0, 4'h0, 8'h5A};
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		wfor(0, 1'b0, 40);
		// register table: defaults, write-back, unmapped offset
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].a, rows[i].d);
			chk(rd & rows[i].m, rows[i].x);
			chk(32'(er), 32'(rows[i].e));
		end
		// idle entry and interrupt wake, with and without service routine
		apb(1'b1, pmrs_pkg::WAKE_ENABLE_OFS, 32'hA0);
		for (i = 0; i < 2; i++) begin
			apb(1'b1, pmrs_pkg::POWER_CONTROL_OFS, {27'h0, i[0], 4'h1});
			repeat (3) @(posedge clk);
			chk(32'({cpu_clk_en, periph_clk_en}), 32'h1);
			port_reg <= 8'hC3;
			repeat (3) @(posedge clk);
			chk(32'(port_out), 32'h5A);
			periph_int <= 1'b1;
			wfor(1, 1'b1, 10);
			chk(32'(wake_service), 32'(i == 0));
			periph_int <= 1'b0;
			port_reg   <= 8'h5A;
			apb(1'b0, pmrs_pkg::POWER_CONTROL_OFS, 32'h0);
			chk(rd, {27'h0, i[0], 4'h0});
		end
		// watchdog time-out interrupt wakes idle, then flag cleared by restart
		apb(1'b1, pmrs_pkg::WATCHDOG_OFS, 32'h2);
		apb(1'b1, pmrs_pkg::POWER_CONTROL_OFS, 32'h1);
		pulse_wd();
		wfor(1, 1'b1, 10);
		chk(32'(wake_service), 32'h1);
		apb(1'b1, pmrs_pkg::WATCHDOG_OFS, 32'h4);
		// external reset while idle; flags cleared beforehand
		apb(1'b1, pmrs_pkg::STATUS_OFS, 32'h300);
		apb(1'b1, pmrs_pkg::POWER_CONTROL_OFS, 32'h1);
		rst_req <= 1'b1;
		@(posedge clk);
		rst_req <= 1'b0;
		wfor(0, 1'b1, 30);
		wfor(0, 1'b0, 40);
		rng(7, 16);
		apb(1'b0, pmrs_pkg::WAKE_ENABLE_OFS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, pmrs_pkg::STATUS_OFS, 32'h0);
		chk(rd & 32'h31F, 32'h1);
		// watchdog time-out with reset enabled
		apb(1'b1, pmrs_pkg::WATCHDOG_OFS, 32'h1);
		pulse_wd();
		wfor(0, 1'b1, 600);
		rng(508, 516);
		wfor(0, 1'b0, 20);
		rng(6, 9);
		apb(1'b0, pmrs_pkg::STATUS_OFS, 32'h0);
		chk(rd & 32'h31F, 32'h201);
		// power-down with both bits, watchdog ignored, wake on rc
		apb(1'b1, pmrs_pkg::WAKE_ENABLE_OFS, 32'h81);
		apb(1'b1, pmrs_pkg::POWER_MODE_OFS, 32'h20);
		apb(1'b1, pmrs_pkg::WATCHDOG_OFS, 32'h1);
		apb(1'b1, pmrs_pkg::POWER_CONTROL_OFS, 32'h3);
		repeat (3) @(posedge clk);
		chk(32'({osc_en, cpu_clk_en, periph_clk_en}), 32'h0);
		port_reg <= 8'h3C;
		pulse_wd();
		repeat (600) @(posedge clk);
		chk(32'({reset_out, port_out}), 32'h3C);
		ext_int <= 4'h1;
		wfor(2, 1'b1, 10);
		wfor(1, 1'b1, 66000);
		rng(65520, 65540);
		chk(32'(wake_service), 32'h1);
		ext_int <= 4'h0;
		// power-on event: reset with its own cause flag, watchdog cause cleared
		por_event <= 1'b1;
		@(posedge clk);
		por_event <= 1'b0;
		wfor(0, 1'b1, 3);
		wfor(0, 1'b0, 20);
		apb(1'b0, pmrs_pkg::STATUS_OFS, 32'h0);
		chk(rd & 32'h31F, 32'h101);
		give_verdict();
	end
endmodule // test_pmrs_top
